// ---- nai_addr_pack.sv ----
// Purpose: spread column, page, plane and block fields over five cycles
// Assumes: byte i of the result is address cycle i+1
// Notes: pure combinational
`timescale 1ns/1ps
`default_nettype none
module nai_addr_pack
  import nai_pkg::*;
(
  input wire logic [nai_pkg::COL_W-1:0] col, // column offset
  input wire logic [nai_pkg::PAGE_W-1:0] page, // page in block
  input wire logic plane_sel_bit, // plane or lowest block bit
  input wire logic [nai_pkg::BLK_W-1:0] block, // block number
  output logic [39:0] cyc // five address bytes
);
  logic [ROW_W-1:0] row; // concatenated row address
  assign row = {block, plane_sel_bit, page};
  // upper nibbles of cycles two and five stay low
  assign cyc = {4'h0, row[19:16], row[15:8], row[7:0], 4'h0, col[11:8], col[7:0]};
endmodule
`default_nettype wire

// ---- nai_bus_asserts.sv ----
// Purpose: timing checks on the shared flash bus between the two ends
// Assumes: host strobe phase of four clocks
// Notes: sees only the interface wires
`timescale 1ns/1ps
`default_nettype none
module nai_bus_asserts (
  input wire logic CLK, // bus clock
  input wire logic RST_B, // sync reset, low
  input wire logic cle, // command latch
  input wire logic ale, // address latch
  input wire logic ce_b, // select, low
  input wire logic we_b, // write strobe, low
  input wire logic re_b, // read strobe, low
  input wire logic [7:0] h_io, // host data
  input wire logic h_oe, // host drives
  input wire logic d_oe // device drives
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // a strobe is one phase low, then released
  sequence s_we; !we_b[*4] ##1 we_b; endsequence
  sequence s_re; !re_b[*4] ##1 re_b; endsequence
  property p_we; $fell(we_b) |-> s_we; endproperty
  a_we: assert property (p_we) else $error("write strobe width wrong");
  property p_lat; $rose(we_b) |-> (cle || ale) && !ce_b && h_oe; endproperty
  a_lat: assert property (p_lat) else $error("latch dropped before strobe rise");
  property p_one; !we_b |-> cle != ale; endproperty
  a_one: assert property (p_one) else $error("command and address latch clash");
  // byte and latch must not move while the strobe is low
  property p_stab; !we_b && !$past(we_b) |-> $stable(h_io) && $stable(cle) && $stable(ale);
  endproperty
  a_stab: assert property (p_stab) else $error("write byte moved");
  property p_clash; d_oe |-> !h_oe; endproperty
  a_clash: assert property (p_clash) else $error("both ends drive");
  property p_rsel; !re_b |-> !ce_b && we_b && !h_oe; endproperty
  a_rsel: assert property (p_rsel) else $error("read strobe without select");
  property p_drv; $rose(d_oe) |-> !re_b; endproperty
  a_drv: assert property (p_drv) else $error("device drove without read strobe");
  property p_re; $fell(re_b) |-> s_re; endproperty
  a_re: assert property (p_re) else $error("read strobe width wrong");
endmodule
`default_nettype wire

// ---- nai_device.sv ----
// Purpose: device end of the flash command interface: address capture,
//   per-die status, identification and parameter page
// Assumes: strobes are synchronous to CLK and held at least two cycles
// Notes: array operations are modelled only as a busy countdown
// Behaviour
// - column bits sit in cycles one, two
// - page bits on cycle three, low six
// - row bit 6 is plane or block bit
// - block bits span cycles three to five
// - row address is block, plane, page
// - cycle five upper nibble low, die bits
// - dies run operations independently, status each
// - enhanced status reports addressed plane only
// - 90h then 00h enters identification
// - host sends 00h before status after ID
// - five identification bytes served in order
// - identification persists until next command
// - byte five packs ECC, planes, size
// - ECh then 00h starts parameter page
// - parameter mode persists until next command
// - host resets before parameter page read
// - signature and revision bytes zero to five
// - feature bytes six, seven are 1Eh,00h
// - optional command bytes are 3Bh,00h
// - capture command or address on strobe rise
// - read strobe fall drives next byte
`timescale 1ns/1ps
`default_nettype none
module nai_device
  import nai_pkg::*;
#(
  parameter int BUSY_CYC = BUSY_DEFAULT, // cycles an array operation stays busy
  parameter logic [7:0] ID_MAKER = 8'hA5, // arbitrary value
  parameter logic [7:0] ID_DEV = 8'h3C, // arbitrary value
  parameter logic [7:0] ID_B3 = 8'h11, // arbitrary value
  parameter logic [7:0] ID_B4 = 8'h22, // arbitrary value
  parameter logic [1:0] ID5_ECC = 2'h0, // ecc level code, arbitrary
  parameter logic [1:0] ID5_PLANES = 2'h0, // plane count code, arbitrary
  parameter logic [2:0] ID5_SIZE = 3'h0 // plane size code, arbitrary
) (
  input wire logic CLK, // 200 MHz clock
  input wire logic RST_B, // synchronous reset, low active
  nai_if.dev NAND, // flash bus
  output logic [3:0] DIE_READY, // one per die, high when idle
  output logic [nai_pkg::ROW_W-1:0] ROW_ADDR, // last captured row address
  output logic [nai_pkg::COL_W-1:0] COL_ADDR // last captured column
);
  // the countdown must fit its eight-bit counters
  if (BUSY_CYC < 1 || BUSY_CYC > 255) begin : g_chk
    $error("BUSY_CYC must be 1 to 255");
  end

  localparam logic [7:0] BUSY_LOAD = 8'(BUSY_CYC); // reload for a started operation

  typedef struct packed {
    nai_dst_t st; // bus mode
    logic [7:0] cmd; // last command byte
    logic [2:0] acnt; // next address cycle index
    logic [COL_W-1:0] col; // column field
    logic [ROW_W-1:0] row; // block, plane and page fields
    logic [11:0] rcnt; // read column counter
    logic we_q; // write strobe one cycle ago
    logic re_q; // read strobe one cycle ago
    logic [7:0] dq; // byte driven to the bus
    logic dq_oe; // drive enable
    logic rst_seen; // a reset command has been taken
    logic [1:0] sel_die; // die for plain status
    logic [7:0][7:0] busy; // countdown per die and plane
    logic [3:0] die_rdy; // registered readiness
  } nai_dev_s_t;

  nai_dev_s_t s_r; // registered state
  nai_dev_s_t s_nxt; // next state

  logic we_rise; // write strobe rising
  logic re_fall; // read strobe falling
  logic [2:0] op_idx; // die and plane that the row address names
  logic [2:0] enh_idx; // die and plane for enhanced status
  logic stat_rdy; // readiness reported in the status byte
  logic [7:0] id_byte; // identification byte at the read column
  logic [7:0] stat_byte; // status byte

  assign we_rise = NAND.we_b & ~s_r.we_q;
  assign re_fall = ~NAND.re_b & s_r.re_q;
  // die is the top two block bits, plane is the bit shared with the block field
  assign op_idx = {s_r.row[ROW_W-1:DIE_LSB], s_r.row[PLANE_POS]};
  assign enh_idx = op_idx;

  // status source: enhanced status names one plane, plain status one die
  always_comb begin
    if (s_r.cmd == CMD_STAT_ENH) begin
      stat_rdy = (s_r.busy[enh_idx] == 8'h00);
    end else begin
      stat_rdy = s_r.die_rdy[s_r.sel_die];
    end
    stat_byte = 8'h00;
    stat_byte[STAT_NWP_BIT] = 1'b1;
    stat_byte[STAT_RDY_BIT] = stat_rdy;
    stat_byte[STAT_ARDY_BIT] = stat_rdy;
  end

  // identification bytes; past the fifth the bus reads zero
  always_comb begin
    case (s_r.rcnt)
      12'h000: id_byte = ID_MAKER;
      12'h001: id_byte = ID_DEV;
      12'h002: id_byte = ID_B3;
      12'h003: id_byte = ID_B4;
      12'h004: id_byte = {1'b0, ID5_SIZE, ID5_PLANES, ID5_ECC};
      default: id_byte = 8'h00;
    endcase
  end

  // next-state logic for bus decode, countdowns and read data
  always_comb begin
    s_nxt = s_r;
    s_nxt.we_q = NAND.we_b;
    s_nxt.re_q = NAND.re_b;
    // every die and plane counts down on its own, so dies overlap
    for (int i = 0; i < 8; i++) begin
      if (s_r.busy[i] != 8'h00) begin
        s_nxt.busy[i] = s_r.busy[i] - 8'h01;
      end
    end
    for (int d = 0; d < 4; d++) begin
      s_nxt.die_rdy[d] = (s_r.busy[2*d] == 8'h00) && (s_r.busy[2*d+1] == 8'h00);
    end
    if (we_rise && !NAND.ce_b && NAND.cle) begin
      // any command leaves the identification or parameter mode
      s_nxt.cmd = NAND.io;
      s_nxt.rcnt = 12'h000;
      s_nxt.acnt = 3'h0;
      case (NAND.io)
        CMD_ID, CMD_PARAM, CMD_READ, CMD_PROG: begin
          s_nxt.st = D_ADDR;
        end
        CMD_ERASE, CMD_STAT_ENH: begin
          // row-only sequences start at the third cycle
          s_nxt.st = D_ADDR;
          s_nxt.acnt = ROW_FIRST_CYC;
        end
        CMD_STATUS: begin
          s_nxt.st = D_STAT;
        end
        CMD_RESET: begin
          // reset aborts every operation; it also arms the parameter page
          s_nxt.st = D_IDLE;
          s_nxt.rst_seen = 1'b1;
          s_nxt.busy = '0;
        end
        CMD_READ_GO, CMD_PROG_GO, CMD_ERASE_GO: begin
          // confirm starts the operation only if its plane is idle
          s_nxt.st = D_IDLE;
          s_nxt.sel_die = s_r.row[ROW_W-1:DIE_LSB];
          if ((NAND.io == CMD_READ_GO && s_r.cmd == CMD_READ) ||
              (NAND.io == CMD_PROG_GO && s_r.cmd == CMD_PROG) ||
              (NAND.io == CMD_ERASE_GO && s_r.cmd == CMD_ERASE)) begin
            if (s_r.busy[op_idx] == 8'h00) begin
              s_nxt.busy[op_idx] = BUSY_LOAD;
            end
          end
        end
        default: begin
          s_nxt.st = D_IDLE;
        end
      endcase
    end else if (we_rise && !NAND.ce_b && NAND.ale && s_r.st == D_ADDR) begin
      // address byte lands in its field by cycle index
      case (s_r.acnt)
        3'h0: s_nxt.col[7:0] = NAND.io;
        3'h1: s_nxt.col[11:8] = NAND.io[3:0];
        3'h2: s_nxt.row[7:0] = NAND.io;
        3'h3: s_nxt.row[15:8] = NAND.io;
        3'h4: s_nxt.row[19:16] = NAND.io[3:0];
        default: s_nxt.row = s_r.row;
      endcase
      if (s_r.acnt != LAST_CYC) begin
        s_nxt.acnt = s_r.acnt + 3'h1;
      end
      if (s_r.cmd == CMD_ID || s_r.cmd == CMD_PARAM) begin
        // one address byte ends the sequence; only 00h opens the mode
        if (NAND.io != ADDR_ZERO) begin
          s_nxt.st = D_IDLE;
        end else if (s_r.cmd == CMD_ID) begin
          s_nxt.st = D_ID;
        end else begin
          s_nxt.st = D_PARAM;
        end
      end else if (s_r.cmd == CMD_STAT_ENH && s_r.acnt == LAST_CYC) begin
        s_nxt.st = D_STAT;
        s_nxt.sel_die = NAND.io[3:2];
      end
    end
    // each read strobe fall loads the next byte and steps the column
    if (re_fall && !NAND.ce_b) begin
      s_nxt.rcnt = s_r.rcnt + 12'h001;
      case (s_r.st)
        D_ID: s_nxt.dq = id_byte;
        D_PARAM: begin
          // zero bytes until a reset command has been seen
          if (s_r.rst_seen && s_r.rcnt < PARAM_LEN) begin
            s_nxt.dq = PARAM_TABLE[s_r.rcnt[3:0]];
          end else begin
            s_nxt.dq = 8'h00;
          end
        end
        D_STAT: s_nxt.dq = stat_byte;
        default: s_nxt.dq = 8'h00;
      endcase
    end
    // drive only while the host holds the read strobe low in a read mode
    s_nxt.dq_oe = !NAND.re_b && !NAND.ce_b && !NAND.h_oe &&
                  (s_r.st == D_ID || s_r.st == D_PARAM || s_r.st == D_STAT);
  end

  // single state register; reset values are all constants
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s_r <= '0;
      s_r.st <= D_IDLE;
      s_r.we_q <= 1'b1;
      s_r.re_q <= 1'b1;
      s_r.die_rdy <= 4'hF;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign NAND.d_io = s_r.dq;
  assign NAND.d_oe = s_r.dq_oe;
  assign DIE_READY = s_r.die_rdy;
  assign ROW_ADDR = s_r.row;
  assign COL_ADDR = s_r.col;
endmodule
`default_nettype wire

// ---- nai_host.sv ----
// Purpose: host end: AXI4-Lite registers turned into flash bus cycles
// Assumes: one AXI write and one read under way at a time
// Notes: strobe phases step on a divider tick of DIV clocks
//
// The implementer's own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module nai_host
  import nai_pkg::*;
#(
  parameter int DIV = DIV_DEFAULT // clocks per strobe phase
) (
  input wire logic CLK, // 200 MHz clock
  input wire logic RST_B, // synchronous reset, low active
  nai_if.host NAND, // flash bus
  input wire logic [31:0] S_AXI_AWADDR, // write address
  input wire logic S_AXI_AWVALID, // write address valid
  output logic S_AXI_AWREADY, // write address ready
  input wire logic [31:0] S_AXI_WDATA, // write data
  input wire logic [3:0] S_AXI_WSTRB, // byte enables
  input wire logic S_AXI_WVALID, // write data valid
  output logic S_AXI_WREADY, // write data ready
  output logic [1:0] S_AXI_BRESP, // write response
  output logic S_AXI_BVALID, // write response valid
  input wire logic S_AXI_BREADY, // write response ready
  input wire logic [31:0] S_AXI_ARADDR, // read address
  input wire logic S_AXI_ARVALID, // read address valid
  output logic S_AXI_ARREADY, // read address ready
  output logic [31:0] S_AXI_RDATA, // read data
  output logic [1:0] S_AXI_RRESP, // read response
  output logic S_AXI_RVALID, // read data valid
  input wire logic S_AXI_RREADY // read data ready
);
  // the device needs one clock after a read fall before the sample
  if (DIV < 3 || DIV > 255) begin : g_chk
    $error("DIV must be 3 to 255");
  end

  localparam logic [7:0] DIV_LAST = 8'(DIV - 1); // divider wrap value

  typedef struct packed {
    nai_hst_t st; // bus sequencer state
    logic [7:0] div; // divider count
    logic [2:0] op; // current operation
    logic [7:0] byt; // command or address byte
    logic [7:0] pre; // byte inserted ahead of the command
    logic pre_v; // insertion pending
    logic [2:0] idx; // address cycle index
    logic id_mode; // last command opened identification
    logic [COL_W-1:0] col; // column register
    logic [ROW_W-1:0] row; // page, plane, block register
    logic [7:0] rbyte; // last byte read
    logic cle, ale, ce_b, we_b, re_b, oe; // bus controls
    logic [7:0] io; // bus data
    logic awr, wr, awg, wg, bv, arr, rv; // axi handshake flags
    logic [11:0] awa; // latched write address
    logic [31:0] wd; // latched write data
    logic [3:0] ws; // latched byte enables
    logic [1:0] br, rr; // responses
    logic [31:0] rd; // read data
  } nai_host_s_t;

  nai_host_s_t s_r; // registered state
  nai_host_s_t s_nxt; // next state
  logic tick; // one-cycle strobe phase enable
  logic [39:0] cyc; // packed address cycles
  logic [7:0] cur; // byte of the unit being sent
  logic more_addr; // further address cycles remain

  nai_addr_pack u_pack (
    .col(s_r.col),
    .page(s_r.row[PAGE_W-1:0]),
    .plane_sel_bit(s_r.row[PLANE_POS]),
    .block(s_r.row[ROW_W-1:PLANE_POS+1]),
    .cyc(cyc)
  );

  assign tick = (s_r.div == DIV_LAST);
  assign more_addr = (s_r.op == OP_FULL || s_r.op == OP_ROW) && s_r.idx != LAST_CYC;
  // pick the byte of the current unit
  always_comb begin
    case (s_r.op)
      OP_CMD: cur = s_r.pre_v ? s_r.pre : s_r.byt;
      OP_FULL, OP_ROW: cur = cyc[{s_r.idx, 3'h0} +: 8];
      default: cur = s_r.byt;
    endcase
  end

  // sequencer and register slave
  always_comb begin
    s_nxt = s_r;
    s_nxt.div = tick ? 8'h00 : s_r.div + 8'h01;
    if (tick) begin
      case (s_r.st)
        H_SETUP: begin
          // latch lines, data and write strobe low together
          s_nxt.cle = (s_r.op == OP_CMD);
          s_nxt.ale = (s_r.op != OP_CMD);
          s_nxt.io = cur;
          s_nxt.oe = 1'b1;
          s_nxt.ce_b = 1'b0;
          s_nxt.we_b = 1'b0;
          if (s_r.op == OP_CMD) begin
            s_nxt.id_mode = (cur == CMD_ID);
          end
          s_nxt.st = H_WEH;
        end
        H_WEH: begin
          s_nxt.we_b = 1'b1;
          s_nxt.st = H_HOLD;
        end
        H_HOLD: begin
          s_nxt.cle = 1'b0;
          s_nxt.ale = 1'b0;
          s_nxt.oe = 1'b0;
          if (s_r.op == OP_CMD && s_r.pre_v) begin
            s_nxt.pre_v = 1'b0;
            s_nxt.st = H_SETUP;
          end else if (more_addr) begin
            s_nxt.idx = s_r.idx + 3'h1;
            s_nxt.st = H_SETUP;
          end else begin
            s_nxt.ce_b = 1'b1;
            s_nxt.st = H_IDLE;
          end
        end
        H_RDL: begin
          s_nxt.ce_b = 1'b0;
          s_nxt.re_b = 1'b0;
          s_nxt.st = H_RDS;
        end
        H_RDS: begin
          s_nxt.rbyte = NAND.io;
          s_nxt.re_b = 1'b1;
          s_nxt.ce_b = 1'b1;
          s_nxt.st = H_IDLE;
        end
        default: s_nxt.st = H_IDLE;
      endcase
    end
    // write channels are taken in either order
    if (S_AXI_AWVALID && s_r.awr) begin
      s_nxt.awr = 1'b0;
      s_nxt.awg = 1'b1;
      s_nxt.awa = S_AXI_AWADDR[11:0];
    end
    if (S_AXI_WVALID && s_r.wr) begin
      s_nxt.wr = 1'b0;
      s_nxt.wg = 1'b1;
      s_nxt.wd = S_AXI_WDATA;
      s_nxt.ws = S_AXI_WSTRB;
    end
    if (s_r.awg && s_r.wg && !s_r.bv) begin
      s_nxt.awg = 1'b0;
      s_nxt.wg = 1'b0;
      s_nxt.bv = 1'b1;
      s_nxt.br = RESP_SLVERR;
      if (s_r.ws == 4'hF) begin
        case (s_r.awa)
          REG_CTRL: begin
            // a new operation is refused while one runs
            if (s_r.st == H_IDLE) begin
              s_nxt.br = RESP_OKAY;
              s_nxt.op = s_r.wd[10:8];
              s_nxt.byt = s_r.wd[7:0];
              s_nxt.pre_v = 1'b0;
              s_nxt.idx = (s_r.wd[10:8] == OP_ROW) ? ROW_FIRST_CYC : 3'h0;
              s_nxt.st = (s_r.wd[10:8] == OP_READ) ? H_RDL : H_SETUP;
              if (s_r.wd[10:8] == OP_CMD && s_r.wd[7:0] == CMD_STATUS && s_r.id_mode) begin
                s_nxt.pre = CMD_READ;
                s_nxt.pre_v = 1'b1;
              end
              if (s_r.wd[10:8] == OP_CMD && s_r.wd[7:0] == CMD_PARAM) begin
                s_nxt.pre = CMD_RESET;
                s_nxt.pre_v = 1'b1;
              end
              if (s_r.wd[10:8] > OP_ROW) begin
                s_nxt.br = RESP_SLVERR;
                s_nxt.st = H_IDLE;
              end
            end
          end
          REG_COL: begin
            s_nxt.col = s_r.wd[COL_W-1:0];
            s_nxt.br = RESP_OKAY;
          end
          REG_ROW: begin
            s_nxt.row = s_r.wd[ROW_W-1:0];
            s_nxt.br = RESP_OKAY;
          end
          default: s_nxt.br = RESP_SLVERR;
        endcase
      end
    end
    if (s_r.bv && S_AXI_BREADY) begin
      s_nxt.bv = 1'b0;
      s_nxt.awr = 1'b1;
      s_nxt.wr = 1'b1;
    end
    // reads answer one cycle after the address is taken
    if (S_AXI_ARVALID && s_r.arr) begin
      s_nxt.arr = 1'b0;
      s_nxt.rv = 1'b1;
      s_nxt.rr = RESP_OKAY;
      case (S_AXI_ARADDR[11:0])
        REG_CTRL: s_nxt.rd = {21'h0, s_r.op, s_r.byt};
        REG_STAT: s_nxt.rd = {15'h0, s_r.id_mode, s_r.rbyte, 7'h0, s_r.st != H_IDLE};
        REG_COL: s_nxt.rd = {20'h0, s_r.col};
        REG_ROW: s_nxt.rd = {12'h0, s_r.row};
        default: begin
          s_nxt.rd = 32'h0;
          s_nxt.rr = RESP_SLVERR;
        end
      endcase
    end
    if (s_r.rv && S_AXI_RREADY) begin
      s_nxt.rv = 1'b0;
      s_nxt.arr = 1'b1;
    end
  end

  // single state register
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      s_r <= '0;
      s_r.st <= H_IDLE;
      s_r.ce_b <= 1'b1;
      s_r.we_b <= 1'b1;
      s_r.re_b <= 1'b1;
      s_r.awr <= 1'b1;
      s_r.wr <= 1'b1;
      s_r.arr <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign NAND.cle = s_r.cle;
  assign NAND.ale = s_r.ale;
  assign NAND.ce_b = s_r.ce_b;
  assign NAND.we_b = s_r.we_b;
  assign NAND.re_b = s_r.re_b;
  assign NAND.h_io = s_r.io;
  assign NAND.h_oe = s_r.oe;
  assign S_AXI_AWREADY = s_r.awr;
  assign S_AXI_WREADY = s_r.wr;
  assign S_AXI_BVALID = s_r.bv;
  assign S_AXI_BRESP = s_r.br;
  assign S_AXI_ARREADY = s_r.arr;
  assign S_AXI_RVALID = s_r.rv;
  assign S_AXI_RDATA = s_r.rd;
  assign S_AXI_RRESP = s_r.rr;
endmodule
`default_nettype wire

// ---- nai_if.sv ----
// Purpose: multiplexed 8-bit flash bus between host and device
// Assumes: both ends on one clock
// Notes: the shared data wire is resolved here from the two enables
`timescale 1ns/1ps
`default_nettype none
interface nai_if;
  logic cle; // command latch enable
  logic ale; // address latch enable
  logic ce_b; // chip select, low active
  logic we_b; // write strobe, low active
  logic re_b; // read strobe, low active
  logic [7:0] h_io; // host data out
  logic h_oe; // host drives data
  logic [7:0] d_io; // device data out
  logic d_oe; // device drives data
  logic [7:0] io; // resolved bus level
  // device wins only while reading; an undriven bus reads as zero
  assign io = d_oe ? d_io : (h_oe ? h_io : 8'h00);
  modport host (output cle, ale, ce_b, we_b, re_b, h_io, h_oe, input io, d_oe);
  modport dev (input cle, ale, ce_b, we_b, re_b, io, h_oe, output d_io, d_oe);
endinterface
`default_nettype wire

// ---- nai_pkg.sv ----
// Purpose: shared constants and types for the flash command interface pair
// Assumes: one 200 MHz clock, synchronous active-low reset
// Notes: byte lanes of the five address cycles are packed low cycle first
package nai_pkg;
  // command bytes seen on the bus
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_READ_GO = 8'h30;
  localparam logic [7:0] CMD_PROG = 8'h80;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_ERASE = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO = 8'hD0;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_STAT_ENH = 8'h78;
  localparam logic [7:0] CMD_ID = 8'h90;
  localparam logic [7:0] CMD_PARAM = 8'hEC;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam logic [7:0] ADDR_ZERO = 8'h00;
  // address field widths and cycle positions
  localparam int COL_W = 12;
  localparam int PAGE_W = 6;
  localparam int BLK_W = 13;
  localparam int ROW_W = 20;
  localparam int PLANE_POS = 6;
  localparam int DIE_LSB = 18;
  localparam logic [2:0] ROW_FIRST_CYC = 3'h2;
  localparam logic [2:0] LAST_CYC = 3'h4;
  // identification and parameter page layout
  localparam logic [11:0] ID_LEN = 12'h005;
  localparam logic [11:0] PARAM_LEN = 12'h00A;
  localparam logic [9:0][7:0] PARAM_TABLE = {8'h00, 8'h3B, 8'h00, 8'h1E, 8'h00,
                                             8'h02, 8'h49, 8'h46, 8'h4E, 8'h4F};
  // status byte bit positions
  localparam int STAT_NWP_BIT = 7;
  localparam int STAT_RDY_BIT = 6;
  localparam int STAT_ARDY_BIT = 5;
  // host register offsets, response codes and parameter defaults
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_COL = 12'h008;
  localparam logic [11:0] REG_ROW = 12'h00C;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int DIV_DEFAULT = 4;
  localparam int BUSY_DEFAULT = 16;
  // host operation codes written to the control register
  localparam logic [2:0] OP_CMD = 3'h0;
  localparam logic [2:0] OP_ADDR = 3'h1;
  localparam logic [2:0] OP_READ = 3'h2;
  localparam logic [2:0] OP_FULL = 3'h3;
  localparam logic [2:0] OP_ROW = 3'h4;
  typedef enum logic [2:0] {
    D_IDLE = 3'b000, D_ADDR = 3'b001, D_ID = 3'b010, D_PARAM = 3'b011, D_STAT = 3'b100
  } nai_dst_t;
  typedef enum logic [2:0] {
    H_IDLE = 3'b000, H_SETUP = 3'b001, H_WEH = 3'b010, H_HOLD = 3'b011,
    H_RDL = 3'b100, H_RDS = 3'b101
  } nai_hst_t;
endpackage

// ---- nand_address_and_id_tb.sv ----
// Purpose: host and device ends joined, driven over AXI4-Lite
// Assumes: strobe phase of four clocks, default busy count
// Notes: bytes are logged at each write strobe rise
`timescale 1ns/1ps
`default_nettype none
module nand_address_and_id_tb;
  import nai_pkg::*;
  localparam logic [12:0] blk = 13'h1ACE; // block under test
  localparam logic [5:0] pg = 6'h2D; // page under test
  logic clk = 1'b0, rst_b = 1'b0, we_q = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat, s;
  logic awrdy, wrdy, bv, arrdy, rv;
  logic [1:0] br, rresp, r;
  logic [3:0] die_rdy, ws = 4'hF;
  logic [19:0] row_a;
  logic [11:0] col_a;
  logic [7:0] cq[$], aq[$]; // logged command and address bytes
  // default identity bytes of the device, byte five set below
  logic [7:0] idb[5] = '{8'hA5, 8'h3C, 8'h11, 8'h22, {1'b0, 3'h6, 2'h1, 2'h3}};
  logic [7:0] pt[10] = '{8'h4F, 8'h4E, 8'h46, 8'h49, 8'h02, 8'h00, 8'h1E, 8'h00, 8'h3B, 8'h00};
  logic [7:0] ab[5] = '{8'hBC, 8'h0A, {blk[0], 1'b1, pg}, blk[8:1], {4'h0, blk[12:9]}};
  int miscompares = 0, num_checks = 0, cyc = 0;
  nai_if nand_bus ();
  nai_host nai_host_inst (.CLK(clk), .RST_B(rst_b), .NAND(nand_bus),
    .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_BRESP(br),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(bry), .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv),
    .S_AXI_ARREADY(arrdy), .S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
    .S_AXI_RREADY(rry));
  nai_device #(.ID5_ECC(2'h3), .ID5_PLANES(2'h1), .ID5_SIZE(3'h6)) nai_device_inst (.CLK(clk),
    .RST_B(rst_b), .NAND(nand_bus), .DIE_READY(die_rdy), .ROW_ADDR(row_a), .COL_ADDR(col_a));
  nai_bus_asserts nai_bus_asserts_inst (.CLK(clk), .RST_B(rst_b), .cle(nand_bus.cle),
    .ale(nand_bus.ale), .ce_b(nand_bus.ce_b), .we_b(nand_bus.we_b), .re_b(nand_bus.re_b),
    .h_io(nand_bus.h_io), .h_oe(nand_bus.h_oe), .d_oe(nand_bus.d_oe));
  initial forever #2.5 clk = ~clk;
  // log bus bytes and cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (nand_bus.we_b && !we_q && !nand_bus.ce_b) begin
      if (nand_bus.cle) cq.push_back(nand_bus.io);
      if (nand_bus.ale) aq.push_back(nand_bus.io);
    end
    we_q <= nand_bus.we_b;
    if (cyc == 20000) begin
      miscompares++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %0t got %h want %h", $time, g, e);
    end
  endtask
  // one write: address and data offered together, held until taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic dn;
    @(posedge clk);
    awa <= {20'h0, a};
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bv) begin
        r = br;
        bry <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask
  task automatic rd(input logic [11:0] a);
    logic dn;
    @(posedge clk);
    ara <= {20'h0, a};
    arv <= 1'b1;
    rry <= 1'b1;
    dn = 1'b0;
    while (!dn) begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      if (rv) begin
        s = rdat;
        r = rresp;
        rry <= 1'b0;
        dn = 1'b1;
      end
    end
  endtask
  // start a bus operation and poll until the host is idle again
  task automatic op(input logic [2:0] o, input logic [7:0] b);
    wr(REG_CTRL, {21'h0, o, b});
    s = 32'h1;
    while (s[0] !== 1'b0) rd(REG_STAT);
  endtask
  task automatic rb(input logic [7:0] e);
    op(OP_READ, 8'h00);
    chk(s[15:8], e);
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    ws <= 4'h3;
    wr(REG_COL, 32'h0);
    chk(r, RESP_SLVERR);
    ws <= 4'hF;
    wr(12'h010, 32'h0);
    chk(r, RESP_SLVERR);
    wr(REG_STAT, 32'h0);
    chk(r, RESP_SLVERR);
    rd(12'h010);
    chk(r, RESP_SLVERR);
    $display("test refusals done");
    op(OP_CMD, CMD_ID);
    op(OP_ADDR, ADDR_ZERO);
    foreach (idb[i]) rb(idb[i]);
    chk(s[16], 1'b1);
    cq.delete();
    op(OP_CMD, CMD_STATUS);
    chk(cq[0], CMD_READ);
    chk(cq[1], CMD_STATUS);
    $display("test identification done");
    cq.delete();
    op(OP_CMD, CMD_PARAM);
    op(OP_ADDR, ADDR_ZERO);
    chk(cq[0], CMD_RESET);
    foreach (pt[i]) rb(pt[i]);
    $display("test parameter page done");
    aq.delete();
    wr(REG_COL, 32'hABC);
    wr(REG_ROW, {12'h0, blk, 1'b1, pg});
    op(OP_CMD, CMD_READ);
    op(OP_FULL, 8'h00);
    foreach (ab[i]) chk(aq[i], ab[i]);
    chk(row_a, {blk, 1'b1, pg});
    chk(col_a, 12'hABC);
    aq.delete();
    op(OP_CMD, CMD_ERASE);
    op(OP_ROW, 8'h00);
    for (int i = 0; i < 3; i++) chk(aq[i], ab[i + 2]);
    op(OP_CMD, CMD_ERASE_GO);
    chk(die_rdy, 4'h7);
    op(OP_CMD, CMD_STATUS);
    rb(8'hE0);
    $display("test address cycles done");
    report_and_stop();
  end
endmodule
`default_nettype wire
